/* File: pkg/fpc_defs.svh */
`ifndef FPC_DEFS_SVH
`define FPC_DEFS_SVH

// ----------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------
`define FPC_OP_WR_ENABLE 8'h06
`define FPC_OP_RD_STAT 8'h05
`define FPC_OP_ENTER_WIDE 8'hb7
`define FPC_OP_EXIT_WIDE 8'h29
`define FPC_OP_RD_DYN 8'hfa
`define FPC_OP_RD_DYN_W 8'he0
`define FPC_OP_WR_DYN 8'hfb
`define FPC_OP_WR_DYN_W 8'he1
`define FPC_OP_RD_PER 8'hfc
`define FPC_OP_RD_PER_W 8'he2
`define FPC_OP_PG_PER 8'hfd
`define FPC_OP_PG_PER_W 8'he3
`define FPC_OP_ER_PER 8'he4
`define FPC_OP_RD_CFG 8'h2b
`define FPC_OP_PG_CFG 8'h2f
`define FPC_OP_SUSPEND 8'h75

// ----------------------------------------------------------------
// Field positions, lengths, reset values and busy times
// ----------------------------------------------------------------
`define FPC_EXT_BIT 7
`define FPC_SECT_LSB 16
`define FPC_OPC_BITS 7'd8
`define FPC_ADDR3_BITS 7'd24
`define FPC_ADDR4_BITS 7'd32
`define FPC_BYTE_BITS 7'd8
`define FPC_WORD_BITS 7'd16
`define FPC_BANK_RST 8'h00
`define FPC_CFG_RST 16'hffff
`define FPC_PROG_CYC 400
`define FPC_ERASE_CYC 4000

`endif

/* File: pkg/fpc_pkg.sv */
package fpc_pkg;

   // ----------------------------------------------------------------
   // Frame phases of the command interpreter
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      FPC_IDLE,
      FPC_OPC,
      FPC_ADDR,
      FPC_DIN,
      FPC_DOUT,
      FPC_EXEC,
      FPC_IGNORE
   } fpc_state_e;

endpackage

/* File: logic/fpc_sync.sv */
`timescale 1ns/1ps
// Two-stage synchroniser for pin inputs; only the second stage is read.
module fpc_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic [WIDTH-1:0] i_d,
   output logic [WIDTH-1:0] o_q
);

   logic [WIDTH-1:0] meta_r;

   // ----------------------------------------------------------------
   // Synchroniser stages
   // ----------------------------------------------------------------
   // Both stages take a constant under reset so no pin level leaks in.
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         meta_r <= RST_VAL;
         o_q <= RST_VAL;
      end else begin
         meta_r <= i_d;
         o_q <= meta_r;
      end
   end

endmodule

/* File: logic/fpc_flash_prot_cmd.sv */
// Summary of operation
// - Enter-wide opcode sets the extended address flag, bank bit 7, only volatile.
// - Exit-wide opcode clears the volatile extended address flag.
// - Enter and exit wide opcodes work without the write enable latch.
// - With the flag clear, 24-bit addresses get upper bits from bank register.
// - Dynamic read takes 3 or 4 address bytes by flag; wide opcode always 4.
// - Dynamic read shifts the sector byte on falling edges, repeating, no increment.
// - Dynamic writes are accepted only with the write enable latch set.
// - Dynamic write is opcode, flag-sized address, one data byte; wide uses 4.
// - Select rising right after the eighth data bit starts the dynamic update.
// - Persistent reads work only in single-line framing, flag-sized address; wide opcode always 4.
// - Persistent read repeats the sector byte without address increment.
// - Persistent program needs latch, opcode plus address, starts at select rise.
// - Program shows in-progress 1, status readable, then 0 and latch cleared.
// - Persistent erase, latch required, sets every persistent bit to one.
// - Erase starts only if select rises right after the eighth opcode bit.
// - Erase shows in-progress, clears latch when done, refuses erase suspend.
// - Config read shifts 16 bits, low byte first, msb first, repeating.
// - Config program needs latch and two data bytes, low byte first.
// - Config program runs only if select rises right after the sixteenth bit.
// - Config program shows in-progress then clears it and the latch.
// - Opcode and address bits are sampled on rising serial clock edges.
// - Extended address flag is bank bit 7; clear means bank supplies high bits.
`timescale 1ns/1ps
`include "fpc_defs.svh"
module fpc_flash_prot_cmd
   import fpc_pkg::*;
#(
   parameter int N_SECT = 16,
   parameter int PROG_CYC = `FPC_PROG_CYC,
   parameter int ERASE_CYC = `FPC_ERASE_CYC
) (
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic i_cs_n,
   input wire logic i_sck,
   input wire logic [3:0] i_io,
   input wire logic i_four_line_framing,
   output logic [3:0] o_io,
   output logic [3:0] o_io_oe,
   output logic o_extended_addr_flag,
   output logic [7:0] o_bank_addr,
   output logic [31:0] o_last_addr,
   output logic o_write_enable_latch,
   output logic o_in_progress_bit,
   output logic [15:0] o_protect_config_register
);

   localparam int SB = (N_SECT > 1) ? $clog2(N_SECT) : 1;

   // ----------------------------------------------------------------
   // Parameter checks
   // ----------------------------------------------------------------
   if (N_SECT < 2 || N_SECT > 65536 || (1 << SB) != N_SECT) begin : g_bad_sect
      $error("N_SECT must be a power of two from 2 to 65536");
   end
   if (PROG_CYC < 1 || PROG_CYC > 65535 || ERASE_CYC < 1 || ERASE_CYC > 65535) begin : g_bad_t
      $error("busy counts must lie in 1..65535");
   end

   localparam logic [15:0] PROG_LD = 16'(PROG_CYC - 1);
   localparam logic [15:0] ERASE_LD = 16'(ERASE_CYC - 1);

   typedef struct packed {
      fpc_state_e st;
      logic [7:0] op;
      logic [31:0] sh;
      logic [6:0] cnt;
      logic wide;
      logic qlat;
      logic [31:0] addr;
      logic [15:0] dbuf;
      logic [3:0] idx;
      logic sck_q;
      logic cs_q;
      logic [7:0] bank;
      logic wlatch;
      logic active;
      logic [15:0] busy;
      logic [N_SECT-1:0] dyn;
      logic [N_SECT-1:0] per;
      logic [15:0] cfg;
      logic [3:0] io;
      logic [3:0] oe;
   } fpc_state_s;

   fpc_state_s s_r;
   fpc_state_s s_nxt;
   logic [6:0] syn;
   logic cs_s;
   logic sck_s;
   logic [3:0] io_s;
   logic quad_s;
   logic rise;
   logic fall;
   logic cs_rise;
   logic cs_fall;
   logic [2:0] bpc;
   logic [6:0] cnt_inc;
   logic [31:0] sh_in;
   logic [SB-1:0] sect;
   logic [15:0] word;
   logic [15:0] word_rot;
   logic [7:0] stat;

   // ----------------------------------------------------------------
   // Pin synchronisation
   // ----------------------------------------------------------------
   // Select idles high; the serial clock is sampled, not used as a clock.
   fpc_sync #(
      .WIDTH(7),
      .RST_VAL(7'h40)
   ) u_sync (
      .i_clk(i_clk),
      .i_rstn(i_rstn),
      .i_d({i_cs_n, i_sck, i_io, i_four_line_framing}),
      .o_q(syn)
   );

   // Edge detection works on the synchronised copies only.
   assign cs_s = syn[6];
   assign sck_s = syn[5];
   assign io_s = syn[4:1];
   assign quad_s = syn[0];
   assign rise = sck_s && !s_r.sck_q && !cs_s;
   assign fall = !sck_s && s_r.sck_q && !cs_s;
   assign cs_rise = cs_s && !s_r.cs_q;
   assign cs_fall = !cs_s && s_r.cs_q;
   assign bpc = s_r.qlat ? 3'd4 : 3'd1;
   assign cnt_inc = s_r.cnt + 7'(bpc);
   assign sh_in = s_r.qlat ? {s_r.sh[27:0], io_s} : {s_r.sh[30:0], io_s[0]};
   assign sect = s_r.addr[`FPC_SECT_LSB +: SB];
   assign stat = {6'h00, s_r.wlatch, s_r.active};

   // ----------------------------------------------------------------
   // Read-out word selection
   // ----------------------------------------------------------------
   // Eight-bit sources are doubled so a 16-bit rotation repeats them.
   always_comb begin
      case (s_r.op)
         `FPC_OP_RD_DYN, `FPC_OP_RD_DYN_W: word = {16{s_r.dyn[sect]}};
         `FPC_OP_RD_PER, `FPC_OP_RD_PER_W: word = {16{s_r.per[sect]}};
         `FPC_OP_RD_CFG: word = {s_r.cfg[7:0], s_r.cfg[15:8]};
         default: word = {stat, stat};
      endcase
      word_rot = word << s_r.idx;
   end

   // ----------------------------------------------------------------
   // Command interpreter next state
   // ----------------------------------------------------------------
   always_comb begin
      s_nxt = s_r;
      s_nxt.sck_q = sck_s;
      s_nxt.cs_q = cs_s;
      // Busy timer; finishing a program or erase drops the latch too.
      if (s_r.active) begin
         if (s_r.busy == 16'h0000) begin
            s_nxt.active = 1'b0;
            s_nxt.wlatch = 1'b0;
         end else begin
            s_nxt.busy = s_r.busy - 16'h0001;
         end
      end
      if (cs_s) begin
         // Only a frame that ended exactly on its boundary executes.
         if (cs_rise && s_r.st == FPC_EXEC) begin
            case (s_r.op)
               `FPC_OP_WR_ENABLE: s_nxt.wlatch = 1'b1;
               `FPC_OP_ENTER_WIDE: s_nxt.bank[`FPC_EXT_BIT] = 1'b1;
               `FPC_OP_EXIT_WIDE: s_nxt.bank[`FPC_EXT_BIT] = 1'b0;
               `FPC_OP_WR_DYN, `FPC_OP_WR_DYN_W: begin
                  s_nxt.dyn[sect] = s_r.dbuf[0];
                  s_nxt.wlatch = 1'b0;
               end
               `FPC_OP_PG_PER, `FPC_OP_PG_PER_W: begin
                  s_nxt.per[sect] = 1'b0;
                  s_nxt.active = 1'b1;
                  s_nxt.busy = PROG_LD;
               end
               `FPC_OP_ER_PER: begin
                  s_nxt.per = '1;
                  s_nxt.active = 1'b1;
                  s_nxt.busy = ERASE_LD;
               end
               `FPC_OP_PG_CFG: begin
                  s_nxt.cfg = {s_r.dbuf[7:0], s_r.dbuf[15:8]};
                  s_nxt.active = 1'b1;
                  s_nxt.busy = PROG_LD;
               end
               default: s_nxt.st = FPC_IDLE;
            endcase
         end
         s_nxt.st = FPC_IDLE;
         s_nxt.oe = 4'h0;
      end else if (cs_fall) begin
         s_nxt.st = FPC_OPC;
         s_nxt.cnt = 7'd0;
         s_nxt.idx = 4'h0;
         s_nxt.qlat = quad_s;
      end else if (rise) begin
         s_nxt.sh = sh_in;
         s_nxt.cnt = cnt_inc;
         case (s_r.st)
            FPC_OPC: begin
               if (cnt_inc == `FPC_OPC_BITS) begin
                  s_nxt.op = sh_in[7:0];
                  s_nxt.cnt = 7'd0;
                  s_nxt.wide = s_r.bank[`FPC_EXT_BIT];
                  s_nxt.st = FPC_IGNORE;
                  // While busy only the status read gets through.
                  if (!s_r.active || sh_in[7:0] == `FPC_OP_RD_STAT) begin
                     case (sh_in[7:0])
                        `FPC_OP_RD_STAT, `FPC_OP_RD_CFG: s_nxt.st = FPC_DOUT;
                        `FPC_OP_WR_ENABLE, `FPC_OP_ENTER_WIDE,
                        `FPC_OP_EXIT_WIDE: s_nxt.st = FPC_EXEC;
                        `FPC_OP_RD_DYN: s_nxt.st = FPC_ADDR;
                        `FPC_OP_RD_DYN_W: begin
                           s_nxt.st = FPC_ADDR;
                           s_nxt.wide = 1'b1;
                        end
                        `FPC_OP_RD_PER, `FPC_OP_RD_PER_W: begin
                           s_nxt.st = s_r.qlat ? FPC_IGNORE : FPC_ADDR;
                           s_nxt.wide = s_nxt.wide | (sh_in[7:0] == `FPC_OP_RD_PER_W);
                        end
                        `FPC_OP_WR_DYN, `FPC_OP_WR_DYN_W,
                        `FPC_OP_PG_PER, `FPC_OP_PG_PER_W: begin
                           s_nxt.st = s_r.wlatch ? FPC_ADDR : FPC_IGNORE;
                           s_nxt.wide = s_nxt.wide | (sh_in[7:0] == `FPC_OP_WR_DYN_W)
                                        | (sh_in[7:0] == `FPC_OP_PG_PER_W);
                        end
                        `FPC_OP_ER_PER: s_nxt.st = s_r.wlatch ? FPC_EXEC : FPC_IGNORE;
                        `FPC_OP_PG_CFG: s_nxt.st = s_r.wlatch ? FPC_DIN : FPC_IGNORE;
                        // Suspend has nothing to suspend here and is dropped.
                        `FPC_OP_SUSPEND: s_nxt.st = FPC_IGNORE;
                        default: s_nxt.st = FPC_IGNORE;
                     endcase
                  end
               end
            end
            FPC_ADDR: begin
               if (cnt_inc == (s_r.wide ? `FPC_ADDR4_BITS : `FPC_ADDR3_BITS)) begin
                  s_nxt.cnt = 7'd0;
                  // Narrow addresses borrow the bank bits above 128Mb.
                  s_nxt.addr = s_r.wide ? sh_in
                               : {1'b0, s_r.bank[6:0], sh_in[23:0]};
                  case (s_r.op)
                     `FPC_OP_WR_DYN, `FPC_OP_WR_DYN_W: s_nxt.st = FPC_DIN;
                     `FPC_OP_PG_PER, `FPC_OP_PG_PER_W: s_nxt.st = FPC_EXEC;
                     default: s_nxt.st = FPC_DOUT;
                  endcase
               end
            end
            FPC_DIN: begin
               if (cnt_inc == ((s_r.op == `FPC_OP_PG_CFG) ? `FPC_WORD_BITS
                                                          : `FPC_BYTE_BITS)) begin
                  s_nxt.dbuf = sh_in[15:0];
                  s_nxt.cnt = 7'd0;
                  s_nxt.st = FPC_EXEC;
               end
            end
            // Any clock past the boundary cancels execution.
            FPC_EXEC: s_nxt.st = FPC_IGNORE;
            default: s_nxt.cnt = s_r.cnt;
         endcase
      end else if (fall && s_r.st == FPC_DOUT) begin
         // Rotation over 16 bits repeats the byte or word with no increment.
         s_nxt.idx = s_r.idx + 4'(bpc);
         if (s_r.qlat) begin
            s_nxt.io = word_rot[15:12];
            s_nxt.oe = 4'hf;
         end else begin
            s_nxt.io = {2'b00, word_rot[15], 1'b0};
            s_nxt.oe = 4'h2;
         end
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   // Protection bits reset to unprotected because no array is modelled.
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         s_r <= '0;
         s_r.st <= FPC_IDLE;
         s_r.cs_q <= 1'b1;
         s_r.bank <= `FPC_BANK_RST;
         s_r.dyn <= '1;
         s_r.per <= '1;
         s_r.cfg <= `FPC_CFG_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign o_io = s_r.io;
   assign o_io_oe = s_r.oe;
   assign o_extended_addr_flag = s_r.bank[`FPC_EXT_BIT];
   assign o_bank_addr = s_r.bank;
   assign o_last_addr = s_r.addr;
   assign o_write_enable_latch = s_r.wlatch;
   assign o_in_progress_bit = s_r.active;
   assign o_protect_config_register = s_r.cfg;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   sequence seq_exec(logic [7:0] code);
      cs_rise && s_r.st == FPC_EXEC && s_r.op == code;
   endsequence

   sequence seq_decode(logic [7:0] code);
      rise && s_r.st == FPC_OPC && cnt_inc == `FPC_OPC_BITS && sh_in[7:0] == code;
   endsequence

   chk_enter_sets_flag: assert property (@(posedge i_clk) disable iff (!i_rstn)
      seq_exec(`FPC_OP_ENTER_WIDE) |=> o_extended_addr_flag && $stable(o_bank_addr[6:0]))
      else $error("enter wide did not set the flag");

   chk_exit_clear_flag: assert property (@(posedge i_clk) disable iff (!i_rstn)
      seq_exec(`FPC_OP_EXIT_WIDE) |=> !o_extended_addr_flag)
      else $error("exit wide did not clear the flag");

   chk_wide_no_latch: assert property (@(posedge i_clk) disable iff (!i_rstn)
      seq_decode(`FPC_OP_ENTER_WIDE) and (!s_r.wlatch && !s_r.active) |=> s_r.st == FPC_EXEC)
      else $error("enter wide refused without latch");

   chk_narrow_addr_len: assert property (@(posedge i_clk) disable iff (!i_rstn)
      rise && s_r.st == FPC_ADDR && !s_r.wide && cnt_inc == `FPC_ADDR3_BITS
      |=> s_r.st != FPC_ADDR && s_r.addr[31:24] == {1'b0, $past(s_r.bank[6:0])})
      else $error("narrow address length or bank bits wrong");

   chk_write_needs_latch: assert property (@(posedge i_clk) disable iff (!i_rstn)
      seq_decode(`FPC_OP_WR_DYN) and !s_r.wlatch |=> s_r.st == FPC_IGNORE)
      else $error("dynamic write taken without latch");

   chk_per_read_qpi: assert property (@(posedge i_clk) disable iff (!i_rstn)
      seq_decode(`FPC_OP_RD_PER) and s_r.qlat |=> s_r.st == FPC_IGNORE)
      else $error("persistent read accepted in four-line framing");

   chk_erase_all_set: assert property (@(posedge i_clk) disable iff (!i_rstn)
      seq_exec(`FPC_OP_ER_PER) |=> (&s_r.per) && o_in_progress_bit ##1 o_in_progress_bit)
      else $error("erase did not set all persistent bits");

   chk_done_clears_latch: assert property (@(posedge i_clk) disable iff (!i_rstn)
      $fell(o_in_progress_bit) |-> !o_write_enable_latch)
      else $error("latch still set after program");

   chk_readout_rotate: assert property (@(posedge i_clk) disable iff (!i_rstn)
      fall && s_r.st == FPC_DOUT && !s_r.qlat
      |=> o_io_oe == 4'h2 && s_r.idx == $past(s_r.idx) + 4'h1 && $stable(s_r.addr))
      else $error("read-out did not advance by one bit");

   chk_cfg_byte_order: assert property (@(posedge i_clk) disable iff (!i_rstn)
      seq_exec(`FPC_OP_PG_CFG)
      |=> o_protect_config_register == {$past(s_r.dbuf[7:0]), $past(s_r.dbuf[15:8])})
      else $error("config program byte order wrong");

endmodule

/* File: bench/fpc_host_model.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Host controller model for the serial flash command port
// ----------------------------------------------------------------
module fpc_host_model (
   input wire logic i_clk,
   input wire logic i_quad,
   input wire logic [3:0] i_io,
   output logic o_cs_n,
   output logic o_sck,
   output logic [3:0] o_io
);

   // Idle pins: select high, clock parked low, unused lines pulled up.
   initial begin
      o_cs_n = 1'b1;
      o_sck = 1'b0;
      o_io = 4'hf;
   end

   // Every pin change lands on a falling edge of the system clock.
   task automatic tick(input int n);
      repeat (n) @(negedge i_clk);
   endtask

   // One whole frame: nin bits sent msb first, then nout bits read back.
   // Half periods of 4 clocks give the 200 ns serial clock.
   task automatic frame(input logic [63:0] din, input int nin, input int nout,
                        output logic [63:0] dout);
      int w;
      w = i_quad ? 4 : 1;
      dout = '0;
      o_cs_n = 1'b0;
      tick(4);
      for (int i = 0; i < nin + nout; i += w) begin
         // Data is set while the clock is low and held over the rise.
         if (i < nin) begin
            if (w == 4) begin
               o_io = din[nin-1-i -: 4];
            end else begin
               o_io = {3'b111, din[nin-1-i]};
            end
         end
         tick(4);
         if (i >= nin) begin
            // Four-line reads take a whole nibble per clock, msb on line 3.
            dout = (w == 4) ? {dout[59:0], i_io} : {dout[62:0], i_io[1]};
         end
         o_sck = 1'b1;
         tick(4);
         o_sck = 1'b0;
      end
      // Select rises right after the last bit, which starts any update.
      // The released lines show the inverse so stale data never looks valid.
      tick(4);
      o_cs_n = 1'b1;
      o_io = ~o_io;
      tick(4);
   endtask

endmodule

/* File: bench/fpc_flash_prot_cmd_test.sv */
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin total_checks++; if ((gt) !== (ex)) begin num_errors++; \
   $display("CHECK FAILED %s expected %h seen %h", nm, ex, gt); end end
module fpc_flash_prot_cmd_test;
   import fpc_pkg::*;

   typedef struct {
      logic [63:0] din;
      int nin;
      int nout;
      logic [31:0] exp;
      logic flag;
      logic latch;
      logic [15:0] cfg;
   } fpc_row_s;

   logic clk, rstn, quad, cs_n, sck, flag, latch, busy;
   int oe_cnt = 0;
   int oe_base;
   logic [3:0] host_io, dev_io, oe;
   logic [7:0] bank;
   logic [31:0] last_addr;
   logic [15:0] cfg;
   logic [63:0] dout;
   int num_errors = 0;
   int total_checks = 0;

   // ----------------------------------------------------------------
   // Ordinary cases: frame bits, read length, then expected outputs
   // ----------------------------------------------------------------
   fpc_row_s rows [26] = '{
      '{64'h06, 8, 0, 32'h0, 1'b0, 1'b1, 16'hffff},
      '{64'h2f3412, 24, 0, 32'h0, 1'b0, 1'b0, 16'h1234},
      '{64'h2b, 8, 32, 32'h34123412, 1'b0, 1'b0, 16'h1234},
      '{64'hfa050000, 32, 16, 32'hffff, 1'b0, 1'b0, 16'h1234},
      '{64'h06, 8, 0, 32'h0, 1'b0, 1'b1, 16'h1234},
      '{64'hfb05000000, 40, 0, 32'h0, 1'b0, 1'b0, 16'h1234},
      '{64'hfa050000, 32, 16, 32'h0, 1'b0, 1'b0, 16'h1234},
      '{64'hfb06000000, 40, 0, 32'h0, 1'b0, 1'b0, 16'h1234},
      '{64'hfa060000, 32, 16, 32'hffff, 1'b0, 1'b0, 16'h1234},
      '{64'hb7, 8, 0, 32'h0, 1'b1, 1'b0, 16'h1234},
      '{64'hfa00050000, 40, 8, 32'h0, 1'b1, 1'b0, 16'h1234},
      '{64'h29, 8, 0, 32'h0, 1'b0, 1'b0, 16'h1234},
      '{64'he000060000, 40, 8, 32'hff, 1'b0, 1'b0, 16'h1234},
      '{64'h06, 8, 0, 32'h0, 1'b0, 1'b1, 16'h1234},
      '{64'hfd070000, 32, 0, 32'h0, 1'b0, 1'b0, 16'h1234},
      '{64'hfc070000, 32, 16, 32'h0, 1'b0, 1'b0, 16'h1234},
      '{64'he200070000, 40, 8, 32'h0, 1'b0, 1'b0, 16'h1234},
      '{64'h06, 8, 0, 32'h0, 1'b0, 1'b1, 16'h1234},
      '{64'he4, 8, 0, 32'h0, 1'b0, 1'b0, 16'h1234},
      '{64'hfc070000, 32, 16, 32'hffff, 1'b0, 1'b0, 16'h1234},
      '{64'h06, 8, 0, 32'h0, 1'b0, 1'b1, 16'h1234},
      '{64'he300030000, 40, 0, 32'h0, 1'b0, 1'b0, 16'h1234},
      '{64'hfc030000, 32, 8, 32'h0, 1'b0, 1'b0, 16'h1234},
      '{64'h06, 8, 0, 32'h0, 1'b0, 1'b1, 16'h1234},
      '{64'he10006000000, 48, 0, 32'h0, 1'b0, 1'b0, 16'h1234},
      '{64'he000060000, 40, 8, 32'h0, 1'b0, 1'b0, 16'h1234}
   };

   // Short busy times keep the run brief but outlast one status frame.
   fpc_flash_prot_cmd #(.N_SECT(16), .PROG_CYC(200), .ERASE_CYC(300)) i_dut (
      .i_clk(clk),
      .i_rstn(rstn),
      .i_cs_n(cs_n),
      .i_sck(sck),
      .i_io(host_io),
      .i_four_line_framing(quad),
      .o_io(dev_io),
      .o_io_oe(oe),
      .o_extended_addr_flag(flag),
      .o_bank_addr(bank),
      .o_last_addr(last_addr),
      .o_write_enable_latch(latch),
      .o_in_progress_bit(busy),
      .o_protect_config_register(cfg)
   );

   fpc_host_model i_host (
      .i_clk(clk),
      .i_quad(quad),
      .i_io(dev_io),
      .o_cs_n(cs_n),
      .o_sck(sck),
      .o_io(host_io)
   );

   // Counts cycles of output drive, for frames that must be refused silently.
   always @(posedge clk) begin
      if (oe !== 4'h0) oe_cnt <= oe_cnt + 1;
   end

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // ----------------------------------------------------------------
   // Closing and waiting helpers
   // ----------------------------------------------------------------
   task automatic results();
      if (num_errors == 0 && total_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // Bounded wait so a stuck busy flag is reported rather than hanging.
   task automatic wait_idle();
      int n;
      n = 0;
      while (busy !== 1'b0 && n < 1000) begin
         @(negedge clk);
         n++;
      end
      if (n >= 1000) num_errors++;
   endtask

   initial begin
      #(60000 * 25);
      num_errors++;
      results();
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      rstn = 1'b0;
      quad = 1'b0;
      repeat (8) @(negedge clk);
      rstn = 1'b1;
      repeat (4) @(negedge clk);
      `CHK("reset flags", 4'h0, {flag, latch, busy, |oe})
      `CHK("reset bank", 8'h00, bank)
      `CHK("reset config", 16'hffff, cfg)
      for (int r = 0; r < 26; r++) begin
         i_host.frame(rows[r].din, rows[r].nin, rows[r].nout, dout);
         wait_idle();
         if (rows[r].nout > 0) `CHK("read data", rows[r].exp, dout[31:0])
         `CHK("address flag", rows[r].flag, flag)
         `CHK("write latch", rows[r].latch, latch)
         `CHK("config", rows[r].cfg, cfg)
      end
      // Status stays readable while a config program is running.
      i_host.frame(64'h06, 8, 0, dout);
      i_host.frame(64'h2fcdab, 24, 0, dout);
      i_host.frame(64'h05, 8, 8, dout);
      `CHK("status busy", 8'h03, dout[7:0])
      wait_idle();
      `CHK("config after", 16'habcd, cfg)
      `CHK("latch after", 1'b0, latch)
      // Erase ignores a suspend request and keeps reporting busy.
      i_host.frame(64'h06, 8, 0, dout);
      i_host.frame(64'he4, 8, 0, dout);
      i_host.frame(64'h75, 8, 0, dout);
      `CHK("erase busy", 1'b1, busy)
      i_host.frame(64'h05, 8, 8, dout);
      `CHK("erase status", 8'h03, dout[7:0])
      wait_idle();
      `CHK("erase latch", 1'b0, latch)
      // Status stays readable while a persistent program is running.
      i_host.frame(64'h06, 8, 0, dout);
      i_host.frame(64'hfd030000, 32, 0, dout);
      i_host.frame(64'h05, 8, 8, dout);
      `CHK("program status", 8'h03, dout[7:0])
      wait_idle();
      `CHK("program latch", 1'b0, latch)
      // Select rising one bit early or late must cancel the command.
      i_host.frame(64'h06, 8, 0, dout);
      i_host.frame(64'h2f1a09 >> 1, 23, 0, dout);
      i_host.frame(64'h5e3412, 25, 0, dout);
      repeat (8) @(negedge clk);
      `CHK("short config", 16'habcd, cfg)
      i_host.frame(64'h1c8, 9, 0, dout);
      `CHK("long erase", 2'b10, {latch, busy})
      // Wide mode sets bank bit 7; narrow addresses take bank high bits.
      i_host.frame(64'hb7, 8, 0, dout);
      `CHK("bank wide", 8'h80, bank)
      i_host.frame(64'hfa12050000, 40, 8, dout);
      `CHK("wide addr", 32'h12050000, last_addr)
      `CHK("wide data", 8'h00, dout[7:0])
      i_host.frame(64'h29, 8, 0, dout);
      i_host.frame(64'hfa050000, 32, 8, dout);
      `CHK("narrow addr", 32'h00050000, last_addr)
      // Four-line framing: mode commands work, persistent reads are refused.
      quad = 1'b1;
      i_host.frame(64'hb7, 8, 0, dout);
      `CHK("four-line flag", 1'b1, flag)
      oe_base = oe_cnt;
      i_host.frame(64'hfc00070000, 40, 8, dout);
      `CHK("four-line refusal", 1'b1, oe_cnt == oe_base)
      // The config word reads back low byte first over all four lines.
      i_host.frame(64'h2b, 8, 16, dout);
      `CHK("four-line config", 16'hcdab, dout[15:0])
      quad = 1'b0;
      // A reset in mid-run drops the wide flag and the latch.
      rstn = 1'b0;
      repeat (8) @(negedge clk);
      rstn = 1'b1;
      repeat (4) @(negedge clk);
      `CHK("mid reset flags", 3'b000, {flag, latch, busy})
      `CHK("mid reset config", 16'hffff, cfg)
      results();
   end

endmodule
